// [core/frl_pkg.sv]
package frl_pkg;

    localparam int          NUM_CH         = 3;
    localparam int          DUTY_W         = 8;
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  DUTY_MAX       = 8'hFF;
    // register offsets
    localparam logic [7:0]  ADDR_RAMP_STEP_FIRST_CFG1 = 8'h62;
    localparam logic [7:0]  ADDR_RAMP_STEP_FIRST_CFG2 = 8'h63;
    localparam logic [7:0]  ADDR_PWM1_CFG  = 8'h5C;
    localparam logic [7:0]  ADDR_PWM2_CFG  = 8'h5D;
    localparam logic [7:0]  ADDR_PWM3_CFG  = 8'h5E;
    localparam logic [7:0]  ADDR_DUTY1     = 8'h30;
    localparam logic [7:0]  ADDR_DUTY2     = 8'h31;
    localparam logic [7:0]  ADDR_DUTY3     = 8'h32;
    // field positions
    localparam int          CFG1_EN1_BIT   = 3;
    localparam int          CFG1_STEP1_LSB = 0;
    localparam int          CFG2_EN2_BIT   = 7;
    localparam int          CFG2_STEP2_LSB = 4;
    localparam int          CFG2_EN3_BIT   = 3;
    localparam int          CFG2_STEP3_LSB = 0;
    localparam int          PWM_SLOW_BIT   = 3;
    // reset values
    localparam logic [7:0]  RAMP_STEP_FIRST_CFG_RST   = 8'h00;
    localparam logic [7:0]  PWM_CFG_RST    = 8'h00;
    localparam logic [7:0]  DUTY_RST       = 8'h00;
    // slow mode divides the update rate by this
    localparam int          SLOW_DIV       = 4;
    localparam logic [1:0]  SLOW_LAST      = 2'(SLOW_DIV - 1);

    typedef struct packed {
        logic       en;
        logic [2:0] step_code;
        logic       slow;
    } frl_ch_cfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } frl_bus_req_t;

    typedef enum logic [1:0] {
        FRL_HOLD = 2'b00,
        FRL_UP   = 2'b01,
        FRL_DOWN = 2'b11
    } frl_dir_t;

    // step code to time slots
    function automatic logic [7:0] step_slots(input logic [2:0] code);
        case (code)
            3'h0:    step_slots = 8'h01;
            3'h1:    step_slots = 8'h02;
            3'h2:    step_slots = 8'h03;
            3'h3:    step_slots = 8'h05;
            3'h4:    step_slots = 8'h08;
            3'h5:    step_slots = 8'h0C;
            3'h6:    step_slots = 8'h18;
            default: step_slots = 8'h30;
        endcase
    endfunction

endpackage

// [core/frl_ramp_ch.sv]
`timescale 1ns/1ps
`default_nettype none
module frl_ramp_ch (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // configuration
    input  wire frl_pkg::frl_ch_cfg_t cfg,
    // update stream
    input  wire logic                 upd,
    input  wire logic [7:0]           target,
    // result
    output logic [7:0]                duty,
    output frl_pkg::frl_dir_t         dir
);

    logic [7:0]        prev_r;
    logic [1:0]        slow_cnt_r;
    logic [7:0]        step;
    logic [8:0]        up_sum;
    logic [7:0]        prev_nxt;
    logic              step_ok;
    frl_pkg::frl_dir_t dir_nxt;

    assign step    = frl_pkg::step_slots(cfg.step_code);
    assign up_sum  = {1'b0, prev_r} + {1'b0, step};
    // slow mode acts only on every fourth update
    assign step_ok = !cfg.slow || (slow_cnt_r == frl_pkg::SLOW_LAST);

    always_comb begin
        prev_nxt = prev_r;
        dir_nxt  = frl_pkg::FRL_HOLD;
        if (!cfg.en) begin
            prev_nxt = target;
        end else if (target > prev_r) begin
            dir_nxt = frl_pkg::FRL_UP;
            if (step_ok) begin
                // clamp at target and full scale
                if (up_sum > {1'b0, target}) begin
                    prev_nxt = target;
                end else begin
                    prev_nxt = up_sum[7:0];
                end
            end
        end else if (target < prev_r) begin
            dir_nxt = frl_pkg::FRL_DOWN;
            if (step_ok) begin
                // no undershoot past target or zero
                if (prev_r - target < step) begin
                    prev_nxt = target;
                end else begin
                    prev_nxt = prev_r - step;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            prev_r <= frl_pkg::DUTY_RST;
        end else if (upd) begin
            prev_r <= prev_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            slow_cnt_r <= 2'h0;
        end else if (upd && cfg.en && cfg.slow) begin
            slow_cnt_r <= slow_cnt_r + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            dir <= frl_pkg::FRL_HOLD;
        end else if (upd) begin
            dir <= dir_nxt;
        end
    end

    assign duty = prev_r;

endmodule
`default_nettype wire

// [core/frl_ramp_limiter.sv]
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - disabled output follows calculated duty directly
// - smoothing acts on duty, never temperature
// - first config bit 3 enables output one
// - second config bit 7 enables output two
// - second config bit 3 enables output three
// - each output enable acts independently
// - period is 255 slots, step one slot
// - step only 1,2,3,5,8,12,24,48 slots
// - each update compares target with previous duty
// - target above previous: raise by step
// - target below previous: lower by step
// - result saved as previous duty
// - three-bit step fields, codes map to steps
// - slow bit quarters the ramp rate
module frl_ramp_limiter (
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            nrst,
    // register port
    input  wire frl_pkg::frl_bus_req_t           bus,
    output logic [7:0]                           rdata,
    // calculated duty per output, one update strobe each
    input  wire logic [frl_pkg::NUM_CH-1:0]      duty_upd,
    input  wire logic [frl_pkg::NUM_CH-1:0][7:0] duty_target,
    // limited duty per output
    output logic [frl_pkg::NUM_CH-1:0][7:0]      duty_out,
    output logic [frl_pkg::NUM_CH-1:0]           ramping
);

    //////////////////////////////////////////////////////////////////////////
    // configuration registers

    logic [7:0]                               ramp_step_first_cfg1_r;
    logic [7:0]                               ramp_step_first_cfg2_r;
    logic [frl_pkg::NUM_CH-1:0][7:0]          pwm_cfg_r;
    frl_pkg::frl_ch_cfg_t [frl_pkg::NUM_CH-1:0] ch_cfg;
    frl_pkg::frl_dir_t [frl_pkg::NUM_CH-1:0]  ch_dir;
    logic [frl_pkg::NUM_CH-1:0][7:0]          ch_duty;
    logic [7:0]                               rdata_nxt;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ramp_step_first_cfg1_r <= frl_pkg::RAMP_STEP_FIRST_CFG_RST;
        end else if (bus.wr && bus.addr == frl_pkg::ADDR_RAMP_STEP_FIRST_CFG1) begin
            ramp_step_first_cfg1_r <= bus.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ramp_step_first_cfg2_r <= frl_pkg::RAMP_STEP_FIRST_CFG_RST;
        end else if (bus.wr && bus.addr == frl_pkg::ADDR_RAMP_STEP_FIRST_CFG2) begin
            ramp_step_first_cfg2_r <= bus.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pwm_cfg_r <= {frl_pkg::NUM_CH{frl_pkg::PWM_CFG_RST}};
        end else if (bus.wr) begin
            case (bus.addr)
                frl_pkg::ADDR_PWM1_CFG: pwm_cfg_r[0] <= bus.wdata;
                frl_pkg::ADDR_PWM2_CFG: pwm_cfg_r[1] <= bus.wdata;
                frl_pkg::ADDR_PWM3_CFG: pwm_cfg_r[2] <= bus.wdata;
                default: ;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // field decode per output

    always_comb begin
        ch_cfg[0].en        = ramp_step_first_cfg1_r[frl_pkg::CFG1_EN1_BIT];
        ch_cfg[0].step_code = ramp_step_first_cfg1_r[frl_pkg::CFG1_STEP1_LSB +: 3];
        ch_cfg[1].en        = ramp_step_first_cfg2_r[frl_pkg::CFG2_EN2_BIT];
        ch_cfg[1].step_code = ramp_step_first_cfg2_r[frl_pkg::CFG2_STEP2_LSB +: 3];
        ch_cfg[2].en        = ramp_step_first_cfg2_r[frl_pkg::CFG2_EN3_BIT];
        ch_cfg[2].step_code = ramp_step_first_cfg2_r[frl_pkg::CFG2_STEP3_LSB +: 3];
        ch_cfg[0].slow      = pwm_cfg_r[0][frl_pkg::PWM_SLOW_BIT];
        ch_cfg[1].slow      = pwm_cfg_r[1][frl_pkg::PWM_SLOW_BIT];
        ch_cfg[2].slow      = pwm_cfg_r[2][frl_pkg::PWM_SLOW_BIT];
    end

    //////////////////////////////////////////////////////////////////////////
    // one independent limiter per output, acting on duty only

    genvar g;
    generate
        for (g = 0; g < frl_pkg::NUM_CH; g = g + 1) begin : g_ch
            frl_ramp_ch u_ch (
                .clk    (clk),
                .nrst   (nrst),
                .cfg    (ch_cfg[g]),
                .upd    (duty_upd[g]),
                .target (duty_target[g]),
                .duty   (ch_duty[g]),
                .dir    (ch_dir[g])
            );
            assign duty_out[g] = ch_duty[g];
            assign ramping[g]  = (ch_dir[g] != frl_pkg::FRL_HOLD);
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // read port, data one cycle after strobe

    always_comb begin
        case (bus.addr)
            frl_pkg::ADDR_RAMP_STEP_FIRST_CFG1: rdata_nxt = ramp_step_first_cfg1_r;
            frl_pkg::ADDR_RAMP_STEP_FIRST_CFG2: rdata_nxt = ramp_step_first_cfg2_r;
            frl_pkg::ADDR_PWM1_CFG:  rdata_nxt = pwm_cfg_r[0];
            frl_pkg::ADDR_PWM2_CFG:  rdata_nxt = pwm_cfg_r[1];
            frl_pkg::ADDR_PWM3_CFG:  rdata_nxt = pwm_cfg_r[2];
            frl_pkg::ADDR_DUTY1:     rdata_nxt = ch_duty[0];
            frl_pkg::ADDR_DUTY2:     rdata_nxt = ch_duty[1];
            frl_pkg::ADDR_DUTY3:     rdata_nxt = ch_duty[2];
            default:                 rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            rdata <= rdata_nxt;
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// [testbench/frl_ramp_limiter_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module frl_ramp_limiter_assertions (
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            nrst,
    // register port
    input  wire frl_pkg::frl_bus_req_t           bus,
    input  wire logic [7:0]                      rdata,
    // duty path
    input  wire logic [frl_pkg::NUM_CH-1:0]      duty_upd,
    input  wire logic [frl_pkg::NUM_CH-1:0][7:0] duty_target,
    input  wire logic [frl_pkg::NUM_CH-1:0][7:0] duty_out,
    input  wire logic [frl_pkg::NUM_CH-1:0]      ramping
);
    localparam logic [7:0] STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
    logic [7:0] cfg1_r;
    logic [7:0] pwm1_r;
    logic [7:0] stp;
    logic [7:0] exp0;
    logic       go0;
    ////////////////////////////////////////
    // shadow of output one configuration
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg1_r <= frl_pkg::RAMP_STEP_FIRST_CFG_RST;
            pwm1_r <= frl_pkg::PWM_CFG_RST;
        end else if (bus.wr && bus.addr == frl_pkg::ADDR_RAMP_STEP_FIRST_CFG1) begin
            cfg1_r <= bus.wdata;
        end else if (bus.wr && bus.addr == frl_pkg::ADDR_PWM1_CFG) begin
            pwm1_r <= bus.wdata;
        end
    end
    assign stp  = STEPS[cfg1_r[2:0]];
    assign go0  = duty_upd[0] && cfg1_r[3] && !pwm1_r[3];
    assign exp0 = (duty_target[0] > duty_out[0])
        ? ((9'(duty_out[0]) + 9'(stp) >= 9'(duty_target[0])) ? duty_target[0] : duty_out[0] + stp)
        : ((9'(duty_target[0]) + 9'(stp) >= 9'(duty_out[0])) ? duty_target[0] : duty_out[0] - stp);
    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_enabled_step: assert property (
        go0 |=> duty_out[0] == $past(exp0)) else $error("enabled step wrong");
    chk_direct_follow: assert property (
        duty_upd[0] && !cfg1_r[3] |=> duty_out[0] == $past(duty_target[0]))
        else $error("no follow");
    chk_idle_hold: assert property (
        !duty_upd[0] |=> $stable(duty_out[0])) else $error("duty moved without update");
    chk_slow_step: assert property (
        duty_upd[0] && cfg1_r[3] && pwm1_r[3]
        |=> $stable(duty_out[0]) || duty_out[0] == $past(exp0))
        else $error("slow step wrong");
    chk_ramp_flag: assert property (
        go0 |=> ramping[0] == ($past(duty_target[0]) != $past(duty_out[0])))
        else $error("ramping flag");
    chk_rd_idle: assert property (
        !$past(bus.rd) |-> rdata == 8'h00) else $error("rdata not idle");
    chk_rd_duty: assert property (
        bus.rd && bus.addr == frl_pkg::ADDR_DUTY1 |=> rdata == $past(duty_out[0]))
        else $error("duty read");
    chk_rd_cfg: assert property (
        bus.rd && bus.addr == frl_pkg::ADDR_RAMP_STEP_FIRST_CFG1 |=> rdata == $past(cfg1_r))
        else $error("cfg read");
    chk_reset_clear: assert property (disable iff (1'b0)
        !nrst |=> duty_out == '0 && ramping == '0 && rdata == 8'h00) else $error("reset state");
    cover property (go0 && duty_target[0] > duty_out[0]);
    cover property (go0 && duty_target[0] < duty_out[0]);
    cover property (duty_upd[0] && cfg1_r[3] && pwm1_r[3]);
endmodule
bind frl_ramp_limiter frl_ramp_limiter_assertions u_chk (.clk(clk), .nrst(nrst), .bus(bus),
    .rdata(rdata), .duty_upd(duty_upd), .duty_target(duty_target), .duty_out(duty_out),
    .ramping(ramping));
`default_nettype wire

// [testbench/tb_frl_ramp_limiter.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_frl_ramp_limiter;
    logic                  clk;
    logic                  nrst;
    frl_pkg::frl_bus_req_t bus;
    logic [7:0]            rdata;
    logic [2:0]            duty_upd;
    logic [2:0][7:0]       duty_target;
    logic [2:0][7:0]       duty_out;
    logic [2:0]            ramping;
    int                    n_errors;
    int                    total_checks;
    logic [7:0]            steps [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};

    frl_ramp_limiter uut (.clk(clk), .nrst(nrst), .bus(bus), .rdata(rdata), .duty_upd(duty_upd),
        .duty_target(duty_target), .duty_out(duty_out), .ramping(ramping));

    always #5 clk = ~clk;
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // n back-to-back updates of the masked outputs
    task automatic upd(input logic [2:0] m, input logic [7:0] t, input int n);
        @(posedge clk);
        duty_upd    <= m;
        duty_target <= {3{t}};
        repeat (n) @(posedge clk);
        duty_upd <= 3'h0;
        #1;
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        rd(frl_pkg::ADDR_RAMP_STEP_FIRST_CFG1, 8'h00);
        rd(frl_pkg::ADDR_RAMP_STEP_FIRST_CFG2, 8'h00);
        rd(frl_pkg::ADDR_PWM1_CFG, 8'h00);
        rd(8'h7F, 8'h00);
        chk(duty_out[0], 8'h00);
    endtask
    task automatic t_direct();
        upd(3'h7, 8'hA5, 1);
        for (int i = 0; i < 3; i++) chk(duty_out[i], 8'hA5);
        upd(3'h7, 8'h00, 1);
        chk(duty_out[2], 8'h00);
    endtask
    task automatic t_walk();
        logic [7:0] e [4] = '{8'h08, 8'h10, 8'h14, 8'h14};
        wr(frl_pkg::ADDR_RAMP_STEP_FIRST_CFG1, 8'h0C);
        for (int i = 0; i < 4; i++) begin
            upd(3'h1, 8'h14, 1);
            chk(duty_out[0], e[i]);
            chk({7'h00, ramping[0]}, 8'(i < 3));
        end
        chk({7'h00, ramping[0]}, 8'h00);
        upd(3'h1, 8'h00, 1);
        chk(duty_out[0], 8'h0C);
    endtask
    task automatic t_codes();
        wr(frl_pkg::ADDR_RAMP_STEP_FIRST_CFG1, 8'h00);
        upd(3'h1, 8'h00, 1);
        for (int c = 0; c < 8; c++) begin
            wr(frl_pkg::ADDR_RAMP_STEP_FIRST_CFG1, 8'h08 | 8'(c));
            upd(3'h1, 8'hFF, 1);
            chk(duty_out[0], steps[c]);
            upd(3'h1, 8'h00, 1);
            chk(duty_out[0], 8'h00);
        end
    endtask
    task automatic t_indep();
        wr(frl_pkg::ADDR_RAMP_STEP_FIRST_CFG1, 8'h00);
        wr(frl_pkg::ADDR_RAMP_STEP_FIRST_CFG2, 8'h90);
        upd(3'h7, 8'h40, 1);
        chk(duty_out[0], 8'h40);
        chk(duty_out[1], 8'h02);
        chk(duty_out[2], 8'h40);
        chk({5'h00, ramping}, 8'h02);
        wr(frl_pkg::ADDR_RAMP_STEP_FIRST_CFG2, 8'h0B);
        upd(3'h7, 8'h50, 1);
        chk(duty_out[1], 8'h50);
        chk(duty_out[2], 8'h45);
        chk({5'h00, ramping}, 8'h04);
        rd(frl_pkg::ADDR_RAMP_STEP_FIRST_CFG2, 8'h0B);
        rd(frl_pkg::ADDR_DUTY2, 8'h50);
        rd(frl_pkg::ADDR_DUTY3, 8'h45);
        wr(frl_pkg::ADDR_PWM2_CFG, 8'h08);
        upd(3'h2, 8'h33, 1);
        chk(duty_out[1], 8'h33);
        rd(frl_pkg::ADDR_PWM2_CFG, 8'h08);
        wr(frl_pkg::ADDR_PWM3_CFG, 8'h08);
        upd(3'h4, 8'h60, 3);
        chk(duty_out[2], 8'h45);
        upd(3'h4, 8'h60, 1);
        chk(duty_out[2], 8'h4A);
        rd(frl_pkg::ADDR_PWM3_CFG, 8'h08);
    endtask
    task automatic t_slow();
        wr(frl_pkg::ADDR_RAMP_STEP_FIRST_CFG1, 8'h00);
        upd(3'h1, 8'h00, 1);
        wr(frl_pkg::ADDR_PWM1_CFG, 8'h08);
        wr(frl_pkg::ADDR_RAMP_STEP_FIRST_CFG1, 8'h08);
        upd(3'h1, 8'h10, 3);
        chk(duty_out[0], 8'h00);
        upd(3'h1, 8'h10, 1);
        chk(duty_out[0], 8'h01);
        rd(frl_pkg::ADDR_PWM1_CFG, 8'h08);
        wr(frl_pkg::ADDR_DUTY1, 8'h77);
        rd(frl_pkg::ADDR_DUTY1, 8'h01);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        bus = '0;
        duty_upd = '0;
        duty_target = '0;
        n_errors = 0;
        total_checks = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_direct();
        t_walk();
        t_codes();
        t_indep();
        t_slow();
        stop_test();
    end
    initial begin
        #20000;
        n_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
